// ---- inc/lbf_consts.svh ----
// Constants for the two-port learning bridge filter table.
`ifndef LBF_CONSTS_SVH
`define LBF_CONSTS_SVH

`define LBF_ADDR_W   48
`define LBF_DEPTH    2048
`define LBF_PERM_N   16
`define LBF_TMR_W    16
`define LBF_CLK_NS   25
`define LBF_TICK_NS  1000000
`define LBF_TICK_CYC ((`LBF_TICK_NS + `LBF_CLK_NS - 1) / `LBF_CLK_NS)

`endif

// ---- inc/lbf_pkg.sv ----
// Types shared by the learning bridge modules.
`include "lbf_consts.svh"
package lbf_pkg;

    typedef struct packed {
        logic [`LBF_ADDR_W-1:0] src;
        logic [`LBF_ADDR_W-1:0] dst;
        logic                   port;
    } lbf_desc_s;

    typedef struct packed {
        logic                   valid;
        logic                   known;
        logic                   port;
        logic                   fresh;
        logic [`LBF_ADDR_W-1:0] addr;
    } lbf_entry_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOOK = 5'h02,
        ST_DST  = 5'h04,
        ST_WAIT = 5'h08,
        ST_AGE  = 5'h10
    } lbf_state_e;

endpackage

// ---- inc/lbf_if.sv ----
// Valid/ready carrier for forwarded frame descriptors.
`timescale 1ns/1ps
`default_nettype none
interface lbf_if;
    logic              valid;
    logic              ready;
    lbf_pkg::lbf_desc_s data;
    modport tx (output valid, output data, input ready);
    modport rx (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- src/lbf_buf.sv ----
// Two-entry skid buffer between the forwarding logic and the egress.
`timescale 1ns/1ps
`default_nettype none
module lbf_buf (
    input  wire logic sys_clk, // System clock.
    input  wire logic rst_b,   // Synchronous reset, active low.
    lbf_if.rx         enq,     // Filling side.
    lbf_if.tx         deq      // Draining side.
);
    import lbf_pkg::*;

    lbf_desc_s  mem_r [2];
    logic       wp_r;
    logic       rp_r;
    logic [1:0] cnt_r;
    logic       push;
    logic       pop;

    assign enq.ready = (cnt_r != 2'h2);
    assign deq.valid = (cnt_r != 2'h0);
    assign deq.data  = mem_r[rp_r];
    assign push      = enq.valid && enq.ready;
    assign pop       = deq.valid && deq.ready;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            mem_r[0] <= '0;
            mem_r[1] <= '0;
        end else if (push) begin
            mem_r[wp_r] <= enq.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) wp_r <= ~wp_r;
            if (pop) rp_r <= ~rp_r;
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    buf_no_over_a: assert property (cnt_r != 2'h3)
        else $error("Buffer count out of range.");

endmodule
`default_nettype wire

// ---- src/lbf_bridge.sv ----
// Learning bridge core: address table, filtering, aging and overflow alarm.
`timescale 1ns/1ps
`default_nettype none
`include "lbf_consts.svh"
module lbf_bridge #(
    parameter int unsigned TICK_CYC = `LBF_TICK_CYC,
    parameter int unsigned DEPTH    = `LBF_DEPTH,
    parameter int unsigned PERM_N   = `LBF_PERM_N
) (
    input  wire logic                     sys_clk,       // 40 MHz clock.
    input  wire logic                     rst_b,         // Sync reset.
    input  wire logic                     selftest_done, // Self-test over.
    input  wire logic [`LBF_TMR_W-1:0]    fwd_delay_ms,  // Learn-only time.
    input  wire logic [`LBF_TMR_W-1:0]    age_ms,        // Aging interval.
    input  wire logic                     in_valid,      // Frame offered.
    output logic                          in_ready,      // Frame taken.
    input  wire lbf_pkg::lbf_desc_s       in_desc,       // Received frame.
    output logic                          out_valid,     // Frame to send.
    input  wire logic                     out_ready,     // Egress accepts.
    output lbf_pkg::lbf_desc_s            out_desc,      // Port = egress.
    input  wire logic                     perm_wr,       // Write permanent.
    input  wire logic                     perm_del,      // Remove permanent.
    input  wire logic [$clog2(PERM_N)-1:0] perm_idx,     // Permanent slot.
    input  wire logic [`LBF_ADDR_W-1:0]   perm_addr,     // Permanent address.
    input  wire logic                     perm_port,     // Permanent port.
    output logic                          fwd_en,        // Forwarding mode.
    output logic                          filt_pulse,    // Local frame filtered.
    output logic                          full_alarm,    // Table full alarm.
    output logic [$clog2(DEPTH):0]        occupancy      // Dynamic entries.
);
    import lbf_pkg::*;

    localparam int unsigned IW = $clog2(DEPTH);
    localparam int unsigned PW = $clog2(PERM_N);
    localparam logic [IW:0] FULL_LVL  = (IW+1)'(DEPTH);
    localparam logic [IW:0] REARM_LVL = (IW+1)'(DEPTH - DEPTH / 3);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYC - 1);

    function automatic logic [IW-1:0] idx_of(input logic [`LBF_ADDR_W-1:0] a);
        idx_of = a[IW-1:0] ^ a[2*IW-1:IW];
    endfunction

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    lbf_entry_s             tbl_r [DEPTH];
    logic [`LBF_ADDR_W-1:0] perm_addr_r [PERM_N];
    logic                   perm_vld_r [PERM_N];
    logic                   perm_port_r [PERM_N];

    lbf_state_e             st_r;
    lbf_desc_s              cur_r;
    logic                   egress_r;
    logic [IW-1:0]          age_idx_r;
    logic [IW:0]            occ_r;
    logic                   started_r;
    logic                   fwd_en_r;
    logic                   age_pend_r;
    logic                   armed_r;
    logic                   alarm_r;
    logic                   filt_r;
    logic [31:0]            tick_cnt_r;
    logic                   tick;
    logic [`LBF_TMR_W-1:0]  fdly_r;
    logic [`LBF_TMR_W-1:0]  age_cnt_r;

    lbf_if enq_if ();
    lbf_if deq_if ();

    // --------------------------------------------------------------
    // Lookup
    // --------------------------------------------------------------
    logic [IW-1:0] src_idx;
    logic [IW-1:0] dst_idx;
    lbf_entry_s    src_e;
    lbf_entry_s    dst_e;
    lbf_entry_s    age_e;
    logic          full;
    logic          src_hit;
    logic          src_ins;
    logic          dst_hit;
    logic          dst_ins;
    logic          perm_hit;
    logic          perm_prt;
    logic          loc_known;
    logic          loc_port;
    logic          local_drop;
    logic          ovf;
    logic          age_del;

    assign src_idx = idx_of(cur_r.src);
    assign dst_idx = idx_of(cur_r.dst);
    assign src_e   = tbl_r[src_idx];
    assign dst_e   = tbl_r[dst_idx];
    assign age_e   = tbl_r[age_idx_r];
    assign full    = (occ_r == FULL_LVL);
    assign src_hit = src_e.valid && (src_e.addr == cur_r.src);
    assign src_ins = !src_hit && !src_e.valid && !full;
    assign dst_hit = dst_e.valid && (dst_e.addr == cur_r.dst);
    assign dst_ins = fwd_en_r && !perm_hit && !dst_hit
                     && !dst_e.valid && !full;

    always_comb begin
        perm_hit = 1'b0;
        perm_prt = 1'b0;
        for (int i = 0; i < PERM_N; i++) begin
            if (perm_vld_r[i] && perm_addr_r[i] == cur_r.dst) begin
                perm_hit = 1'b1;
                perm_prt = perm_port_r[i];
            end
        end
    end

    assign loc_known  = perm_hit || (dst_hit && dst_e.known);
    assign loc_port   = perm_hit ? perm_prt : dst_e.port;
    assign local_drop = loc_known && (loc_port == cur_r.port);
    assign ovf = full && ((st_r == ST_LOOK && !src_hit)
                 || (st_r == ST_DST && fwd_en_r && !perm_hit && !dst_hit));
    assign age_del = (st_r == ST_AGE) && age_e.valid && !age_e.fresh;

    // --------------------------------------------------------------
    // Frame sequencing
    // --------------------------------------------------------------
    assign in_ready = (st_r == ST_IDLE) && started_r && !age_pend_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            st_r      <= ST_IDLE;
            cur_r     <= '0;
            egress_r  <= 1'b0;
            age_idx_r <= '0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (age_pend_r) begin
                        age_idx_r <= '0;
                        st_r      <= ST_AGE;
                    end else if (in_valid && in_ready) begin
                        cur_r <= in_desc;
                        st_r  <= ST_LOOK;
                    end
                end
                ST_LOOK: st_r <= ST_DST;
                ST_DST: begin
                    if (!fwd_en_r || local_drop) begin
                        st_r <= ST_IDLE;
                    end else begin
                        egress_r <= loc_known ? loc_port : ~cur_r.port;
                        st_r     <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (enq_if.ready) st_r <= ST_IDLE;
                end
                ST_AGE: begin
                    age_idx_r <= age_idx_r + 1'b1;
                    if (age_idx_r == IW'(DEPTH - 1)) st_r <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end

    assign enq_if.valid = (st_r == ST_WAIT);
    assign enq_if.data  = '{src: cur_r.src, dst: cur_r.dst, port: egress_r};

    lbf_buf u_buf (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .enq     (enq_if.rx),
        .deq     (deq_if.tx)
    );

    assign out_valid    = deq_if.valid;
    assign out_desc     = deq_if.data;
    assign deq_if.ready = out_ready;

    // --------------------------------------------------------------
    // Dynamic table update
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < DEPTH; i++) tbl_r[i] <= '0;
        end else if (st_r == ST_LOOK && (src_hit || src_ins)) begin
            tbl_r[src_idx] <= '{valid: 1'b1, known: 1'b1,
                                port: cur_r.port, fresh: 1'b1,
                                addr: cur_r.src};
        end else if (st_r == ST_DST && !perm_hit && dst_hit) begin
            tbl_r[dst_idx].fresh <= 1'b1;
        end else if (st_r == ST_DST && dst_ins) begin
            tbl_r[dst_idx] <= '{valid: 1'b1, known: 1'b0,
                                port: 1'b0, fresh: 1'b1,
                                addr: cur_r.dst};
        end else if (st_r == ST_AGE) begin
            if (age_del) tbl_r[age_idx_r].valid <= 1'b0;
            tbl_r[age_idx_r].fresh <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            occ_r <= '0;
        end else if ((st_r == ST_LOOK && src_ins)
                     || (st_r == ST_DST && dst_ins)) begin
            occ_r <= occ_r + 1'b1;
        end else if (age_del) begin
            occ_r <= occ_r - 1'b1;
        end
    end
    assign occupancy = occ_r;

    // --------------------------------------------------------------
    // Permanent table, untouched by aging
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            for (int i = 0; i < PERM_N; i++) begin
                perm_addr_r[i] <= '0;
                perm_vld_r[i]  <= 1'b0;
                perm_port_r[i] <= 1'b0;
            end
        end else if (perm_wr) begin
            perm_addr_r[perm_idx] <= perm_addr;
            perm_port_r[perm_idx] <= perm_port;
            perm_vld_r[perm_idx]  <= 1'b1;
        end else if (perm_del) begin
            perm_vld_r[perm_idx] <= 1'b0;
        end
    end

    // --------------------------------------------------------------
    // Millisecond tick, forwarding delay and aging timers
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b || tick) tick_cnt_r <= 32'h0;
        else tick_cnt_r <= tick_cnt_r + 32'h1;
    end
    assign tick = (tick_cnt_r == TICK_LAST);

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            started_r <= 1'b0;
            fwd_en_r  <= 1'b0;
            fdly_r    <= '0;
        end else if (!started_r) begin
            if (selftest_done) begin
                started_r <= 1'b1;
                fdly_r    <= fwd_delay_ms;
            end
        end else if (!fwd_en_r) begin
            if (fdly_r == '0) fwd_en_r <= 1'b1;
            else if (tick) fdly_r <= fdly_r - 1'b1;
        end
    end
    assign fwd_en = fwd_en_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            age_cnt_r  <= '0;
            age_pend_r <= 1'b0;
        end else begin
            if (!started_r) begin
                age_cnt_r <= age_ms;
            end else if (tick) begin
                if (age_cnt_r == '0) age_cnt_r <= age_ms;
                else age_cnt_r <= age_cnt_r - 1'b1;
            end
            if (started_r && tick && age_cnt_r == '0) begin
                age_pend_r <= 1'b1;
            end else if (st_r == ST_IDLE) begin
                age_pend_r <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Overflow alarm with hysteresis and discard indication
    // --------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            armed_r <= 1'b1;
            alarm_r <= 1'b0;
        end else begin
            alarm_r <= ovf && armed_r;
            if (ovf) armed_r <= 1'b0;
            else if (occ_r <= REARM_LVL) armed_r <= 1'b1;
        end
    end
    assign full_alarm = alarm_r;

    always_ff @(posedge sys_clk) begin
        if (!rst_b) filt_r <= 1'b0;
        else filt_r <= (st_r == ST_DST) && fwd_en_r && local_drop;
    end
    assign filt_pulse = filt_r;

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    sequence dst_stage;
        st_r == ST_DST && fwd_en_r;
    endsequence

    no_fwd_learn_a: assert property (enq_if.valid |-> fwd_en_r)
        else $error("Frame queued before forwarding mode.");
    fwd_start_a: assert property (started_r && !fwd_en_r && fdly_r == '0
        |=> fwd_en_r)
        else $error("Forwarding mode did not start.");
    src_learn_a: assert property (st_r == ST_LOOK && !full |=>
        tbl_r[$past(src_idx)].valid && tbl_r[$past(src_idx)].fresh
        || $past(src_e.valid && !src_hit))
        else $error("Source address not learned.");
    filter_local_a: assert property (dst_stage and local_drop
        |=> st_r == ST_IDLE && filt_pulse ##1 !enq_if.valid)
        else $error("Local frame was forwarded.");
    unknown_fwd_a: assert property (dst_stage and !loc_known
        |=> st_r == ST_WAIT && egress_r == !$past(cur_r.port))
        else $error("Unknown destination not passed across.");
    fill_loc_a: assert property (st_r == ST_LOOK && src_hit
        |=> tbl_r[$past(src_idx)].known
        && tbl_r[$past(src_idx)].port == $past(cur_r.port))
        else $error("Unknown location not filled in.");
    known_port_a: assert property (dst_stage and loc_known and !local_drop
        |=> egress_r == $past(loc_port))
        else $error("Known destination sent on wrong port.");
    age_purge_a: assert property (age_del |=> !tbl_r[$past(age_idx_r)].valid
        && occ_r == $past(occ_r) - 1'b1)
        else $error("Stale entry survived aging.");
    occ_cap_a: assert property (occ_r <= FULL_LVL)
        else $error("Occupancy beyond table size.");
    alarm_once_a: assert property (full_alarm |-> $past(armed_r)
        ##1 !full_alarm)
        else $error("Alarm raised while disarmed.");

endmodule
`default_nettype wire

// ---- verification/lbf_sink.sv ----
// Egress station model that takes forwarded frame descriptors.
`timescale 1ns/1ps
`default_nettype none
module lbf_sink (
    input  wire logic               sys_clk,   // System clock.
    input  wire logic               rst_b,     // Sync reset, active low.
    input  wire logic               stall,     // Hold ready low.
    input  wire logic               slow,      // Ready every other cycle.
    input  wire logic               out_valid, // Descriptor offered.
    input  wire lbf_pkg::lbf_desc_s out_desc,  // Offered descriptor.
    output logic                    out_ready  // Accept strobe.
);
    import lbf_pkg::*;
    lbf_desc_s got[$];
    logic      ph_r;

    initial begin
        out_ready = 1'b0;
        ph_r = 1'b0;
    end

    // Ready moves just after the edge, so a pop is judged on old values.
    always @(posedge sys_clk) begin
        if (rst_b && out_valid && out_ready) begin
            got.push_back(out_desc);
        end
        ph_r <= ~ph_r;
        out_ready <= rst_b && !stall && (!slow || ph_r);
    end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench for the learning bridge core.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lbf_pkg::*;
    localparam int unsigned TICK  = 4;
    localparam int unsigned DEP   = 4;
    localparam int unsigned PN    = 16;
    localparam int          LIMIT = 6000;
    localparam logic [47:0] A = 48'h10;
    localparam logic [47:0] B = 48'h11;
    localparam logic [47:0] C = 48'h12;
    localparam logic [47:0] D = 48'h13;
    localparam logic [47:0] E = 48'h14;
    localparam logic [47:0] F = 48'h25;
    localparam logic [47:0] P = 48'h100;

    logic        sys_clk, rst_b, selftest_done, in_valid, in_ready;
    logic        out_valid, out_ready, perm_wr, perm_del, perm_port;
    logic        fwd_en, filt_pulse, full_alarm, stall, slow;
    logic [15:0] fwd_delay_ms, age_ms;
    logic [3:0]  perm_idx;
    logic [47:0] perm_addr;
    logic [2:0]  occupancy;
    lbf_desc_s   in_desc, out_desc;
    int          error_cnt, num_checks, cyc, filt_cnt, alarm_cnt;

    lbf_bridge #(.TICK_CYC(TICK), .DEPTH(DEP), .PERM_N(PN)) lbf_bridge_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .selftest_done(selftest_done),
        .fwd_delay_ms(fwd_delay_ms), .age_ms(age_ms),
        .in_valid(in_valid), .in_ready(in_ready), .in_desc(in_desc),
        .out_valid(out_valid), .out_ready(out_ready), .out_desc(out_desc),
        .perm_wr(perm_wr), .perm_del(perm_del), .perm_idx(perm_idx),
        .perm_addr(perm_addr), .perm_port(perm_port), .fwd_en(fwd_en),
        .filt_pulse(filt_pulse), .full_alarm(full_alarm),
        .occupancy(occupancy));

    lbf_sink lbf_sink_inst (
        .sys_clk(sys_clk), .rst_b(rst_b), .stall(stall), .slow(slow),
        .out_valid(out_valid), .out_desc(out_desc), .out_ready(out_ready));

    initial sys_clk = 1'b0;
    always #12.5 sys_clk = ~sys_clk;

    // Event counters and the hang guard.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (filt_pulse === 1'b1) filt_cnt <= filt_cnt + 1;
        if (full_alarm === 1'b1) alarm_cnt <= alarm_cnt + 1;
        if (cyc == LIMIT) begin
            error_cnt++;
            $display("FAIL timeout expected 0 seen 1");
            results();
        end
    end

    task automatic results();
        $display("Checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_val(string what, logic [47:0] exp, logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_bit(string what, logic exp, logic got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic idle(int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Offers one frame and holds it until the core takes it.
    task automatic send(logic [47:0] s, logic [47:0] d, logic p);
        int n;
        n = 0;
        @(negedge sys_clk);
        in_valid = 1'b1;
        in_desc = '{src: s, dst: d, port: p};
        while (in_ready !== 1'b1 && n < 3000) begin
            @(negedge sys_clk);
            n++;
        end
        @(negedge sys_clk);
        in_valid = 1'b0;
    endtask

    task automatic expect_out(logic [47:0] s, logic [47:0] d, logic p);
        lbf_desc_s g;
        int n;
        n = 0;
        while (lbf_sink_inst.got.size() == 0 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        if (lbf_sink_inst.got.size() == 0) begin
            chk_val("egress frame", 48'h1, 48'h0);
        end else begin
            g = lbf_sink_inst.got.pop_front();
            chk_val("egress src", s, g.src);
            chk_val("egress dst", d, g.dst);
            chk_bit("egress port", p, g.port);
        end
    endtask

    task automatic t_learn();
        int t0;
        t0 = cyc;
        selftest_done = 1'b1;
        send(A, B, 1'b0);
        idle(6);
        chk_bit("fwd_en", 1'b0, fwd_en);
        chk_val("egress count", 48'h0, lbf_sink_inst.got.size());
        chk_val("filtered", 48'h0, filt_cnt);
        chk_val("occupancy", 48'h1, occupancy);
        while (fwd_en !== 1'b1 && cyc - t0 < 60) idle(1);
        chk_bit("fwd delay", 1'b1, cyc - t0 >= 28 && cyc - t0 <= 40);
        $display("test learn done");
    endtask

    task automatic t_fwd();
        send(B, A, 1'b0);
        idle(4);
        chk_val("filtered", 48'h1, filt_cnt);
        chk_val("egress count", 48'h0, lbf_sink_inst.got.size());
        chk_val("occupancy", 48'h2, occupancy);
        send(A, C, 1'b0);
        expect_out(A, C, 1'b1);
        chk_val("occupancy", 48'h3, occupancy);
        send(C, A, 1'b1);
        expect_out(C, A, 1'b0);
        send(D, C, 1'b1);
        idle(4);
        chk_val("filtered", 48'h2, filt_cnt);
        chk_val("occupancy", 48'h4, occupancy);
        send(C, P, 1'b1);
        idle(4);
        chk_val("filtered", 48'h3, filt_cnt);
        $display("test forward done");
    endtask

    task automatic t_full();
        chk_val("alarms", 48'h0, alarm_cnt);
        send(E, F, 1'b0);
        expect_out(E, F, 1'b1);
        idle(2);
        chk_val("occupancy", 48'h4, occupancy);
        chk_val("alarms", 48'h1, alarm_cnt);
        send(E, F, 1'b0);
        expect_out(E, F, 1'b1);
        idle(2);
        chk_val("alarms", 48'h1, alarm_cnt);
        $display("test full done");
    endtask

    task automatic t_stall();
        stall = 1'b1;
        repeat (3) send(A, C, 1'b0);
        idle(6);
        chk_bit("in_ready", 1'b0, in_ready);
        chk_val("egress count", 48'h0, lbf_sink_inst.got.size());
        stall = 1'b0;
        slow = 1'b1;
        repeat (3) expect_out(A, C, 1'b1);
        idle(4);
        chk_bit("out_valid", 1'b0, out_valid);
        slow = 1'b0;
        $display("test stall done");
    endtask

    task automatic t_age();
        int n;
        n = 0;
        while (occupancy !== 3'h0 && n < 3000) begin
            idle(1);
            n++;
        end
        chk_val("occupancy", 48'h0, occupancy);
        send(C, P, 1'b1);
        idle(4);
        chk_val("filtered", 48'h4, filt_cnt);
        perm_del = 1'b1;
        idle(1);
        perm_del = 1'b0;
        send(C, P, 1'b1);
        expect_out(C, P, 1'b0);
        send(B, D, 1'b0);
        expect_out(B, D, 1'b1);
        chk_val("occupancy", 48'h4, occupancy);
        send(E, F, 1'b0);
        expect_out(E, F, 1'b1);
        idle(2);
        chk_val("alarms", 48'h2, alarm_cnt);
        $display("test aging done");
    endtask

    initial begin
        {rst_b, selftest_done, in_valid, perm_wr, perm_del} = 5'h0;
        {stall, slow} = 2'h0;
        perm_port = 1'b1;
        perm_idx = 4'h0;
        perm_addr = P;
        fwd_delay_ms = 16'h0008;
        age_ms = 16'h00FF;
        in_desc = '0;
        {error_cnt, num_checks, cyc, filt_cnt, alarm_cnt} = '0;
        idle(5);
        rst_b = 1'b1;
        perm_wr = 1'b1;
        idle(1);
        perm_wr = 1'b0;
        t_learn();
        t_fwd();
        t_full();
        t_stall();
        t_age();
        results();
    end
endmodule
`default_nettype wire
